/* mbs_pkg.sv */
// Purpose: Shared constants for the register space and boot sequencer
// Assumes: 250 MHz system clock
// Notes:   Offsets count from the interrupt controller base
package mbs_pkg;
    localparam int          CLK_MHZ            = 250;
    localparam logic [19:0] SPACE_TAG          = 20'hffff0;
    localparam logic [31:0] IRQ_BASE           = 32'hffff0000;
    localparam logic [31:0] SYS_BASE           = 32'hffff0200;
    localparam logic [31:0] TMR_BASE           = 32'hffff0300;
    localparam logic [11:0] OFF_IRQ_ACTIVE     = 12'h000;
    localparam logic [11:0] OFF_IRQ_RAW        = 12'h004;
    localparam logic [11:0] OFF_IRQ_EN         = 12'h008;
    localparam logic [11:0] OFF_IRQ_DIS        = 12'h00c;
    localparam logic [11:0] OFF_SWI_CFG        = 12'h010;
    localparam logic [11:0] OFF_FIQ_ACTIVE     = 12'h100;
    localparam logic [11:0] OFF_FIQ_RAW        = 12'h104;
    localparam logic [11:0] OFF_FIQ_EN         = 12'h108;
    localparam logic [11:0] OFF_FIQ_DIS        = 12'h10c;
    localparam logic [11:0] OFF_REMAP          = 12'h220;
    localparam logic [11:0] OFF_RST_STAT       = 12'h230;
    localparam logic [11:0] OFF_RST_CLR        = 12'h234;
    localparam logic [11:0] OFF_SER_LO         = 12'h238;
    localparam logic [11:0] OFF_SER_HI         = 12'h23c;
    localparam logic [11:0] OFF_CHKSUM         = 12'h240;
    localparam logic [11:0] OFF_T0_RELOAD      = 12'h300;
    localparam logic [11:0] OFF_T0_CNT_LO      = 12'h304;
    localparam logic [11:0] OFF_T0_CNT_HI      = 12'h308;
    localparam logic [11:0] OFF_T0_CTRL        = 12'h30c;
    localparam logic [11:0] OFF_T0_ICLR        = 12'h310;
    localparam logic [11:0] OFF_T0_CAP         = 12'h314;
    localparam logic [11:0] OFF_T1_RELOAD      = 12'h320;
    localparam logic [11:0] OFF_T1_CNT         = 12'h324;
    localparam logic [11:0] OFF_T1_CTRL        = 12'h328;
    localparam logic [11:0] OFF_T1_ICLR        = 12'h32c;
    localparam logic [11:0] OFF_T1_CAP         = 12'h330;
    localparam logic [31:0] RST_T1_CTRL        = 32'h01000000;
    localparam logic [31:0] RST_ZERO           = 32'h00000000;
    // Arbitrary neutral boot firmware revision
    localparam logic [31:0] RST_FW_REVISION    = 32'h00000101;
    localparam logic [1:0]  SIZE_BYTE          = 2'h0;
    localparam logic [1:0]  SIZE_HALF          = 2'h1;
    localparam logic [1:0]  SIZE_WORD          = 2'h2;
    localparam int          POR_BIT            = 0;
    localparam int          CAL_WORDS          = 8;
    localparam logic [31:0] BOOT_REGION_SIZE   = 32'h00000800;
    localparam logic [31:0] CODE_TOP           = 32'h00098000;
    localparam logic [31:0] BOOT_REGION_BASE   = CODE_TOP - BOOT_REGION_SIZE;
    localparam int          BOOT_TIME_US       = 5000;
    localparam int          WDOG_BOOT_MS       = 30;
    localparam int          DL_REFRESH_US      = 1000;
    localparam int          BOOT_CYCLES        = BOOT_TIME_US * CLK_MHZ;
    localparam int          WDOG_BOOT_CYCLES   = WDOG_BOOT_MS * 1000 * CLK_MHZ;
    localparam int          DL_REFRESH_CYCLES  = DL_REFRESH_US * CLK_MHZ;
    typedef enum logic [2:0] {B_CAPTURE, B_COPY, B_WAIT, B_DOWNLOAD, B_USER} mbs_boot_e;
endpackage : mbs_pkg

/* mbs_watchdog.sv */
// Purpose: Down-counting watchdog used while booting and by user code
// Assumes: Load value is stable while enabled
// Notes:   Expiry is a one-cycle pulse; the counter then reloads
`timescale 1ns/1ps
module mbs_watchdog (
    input  wire logic        clock,      // System clock
    input  wire logic        sys_rst,    // Async reset, active high
    input  wire logic        enable,     // Count while high
    input  wire logic [23:0] load,       // Timeout in cycles
    input  wire logic        refresh,    // Restart pulse
    output logic             expired,    // Timeout pulse
    output logic [23:0]      count       // Remaining cycles
);
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            count <= 24'h000000;
        end else if (!enable || refresh || count == 24'h000000) begin
            count <= load;
        end else begin
            count <= count - 24'h000001;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            expired <= 1'b0;
        end else begin
            expired <= enable && !refresh && count == 24'h000001;
        end
    end
endmodule : mbs_watchdog

/* mbs_mmr_boot.sv */
// What this block does
// (R1) Boot firmware lives in top 2 kB
// (R2) Every reset copies calibration into peripherals
// (R3) Boot may leave some registers non-default
// (R4) Second serial register shows firmware revision
// (R5) Watchdog runs 30 ms during boot
// (R6) Watchdog off after power-on boot exit
// (R7) Other resets keep user watchdog, refresh at exit
// (R8) User watchdog timeout must be 30 ms+
// (R9) Download mode refreshes watchdog periodically
// (R10) Normal boot lasts about 5 ms
// (R11) Download mode left only by reset
// (R12) SRAM untouched unless downloading
// (R13) Registers decoded in top 4 kB only; the code decodes the 4 kB page at ffff0000 instead
// (R14) Word access works on any register
// (R15) Read data little-endian aligned
// (R16) Halfword write zeroes upper sixteen bits
// (R17) Halfword read returns sixteen bits only
// (R18) Software avoids halfword access to words
// (R19) Interrupt, system, timer bases fixed
// (R20) Disable registers clear selected enables
// (R21) Reset clear register clears selected flags
// (R22) Write-only and unmapped reads return zero
// Purpose: Peripheral register space decode plus post-reset boot sequencer
// Assumes: Core bus is same-clock logic; one access per cycle, answered next cycle
// Notes:   Calibration store is combinational on calAddr
`timescale 1ns/1ps
module mbs_mmr_boot #(
    parameter int BOOT_CYCLES       = mbs_pkg::BOOT_CYCLES,
    parameter int WDOG_BOOT_CYCLES  = mbs_pkg::WDOG_BOOT_CYCLES,
    parameter int DL_REFRESH_CYCLES = mbs_pkg::DL_REFRESH_CYCLES
) (
    input  wire logic        clock,            // System clock
    input  wire logic        sys_rst,          // Async reset, active high
    input  wire logic        busSel,           // Access request
    input  wire logic        busWrite,         // 1 store, 0 load
    input  wire logic [1:0]  busSize,          // 0 byte, 1 half, 2 word
    input  wire logic [31:0] busAddr,          // Byte address
    input  wire logic [31:0] busWdata,         // Store data
    output logic [31:0]      busRdata,         // Load data
    output logic             busReady,         // Answer pulse
    input  wire logic [31:0] irqRaw,           // Raw normal interrupt sources
    input  wire logic [31:0] fiqRaw,           // Raw fast interrupt sources
    output logic [31:0]      irqActive,        // Enabled active sources
    output logic [31:0]      fiqActive,        // Enabled active fast sources
    output logic [31:0]      softIrq,          // Software interrupt config
    input  wire logic [15:0] t0CountLo,        // Timer 0 count low
    input  wire logic [31:0] t0CountHi,        // Timer 0 count high
    input  wire logic [31:0] t1CountIn,        // Timer 1 count
    input  wire logic [31:0] t1CaptureIn,      // Timer 1 capture
    output logic [15:0]      t0Reload,         // Timer 0 reload
    output logic [31:0]      t0Control,        // Timer 0 control
    output logic [15:0]      t0Capture,        // Timer 0 capture
    output logic [31:0]      t1Reload,         // Timer 1 reload
    output logic [31:0]      t1Control,        // Timer 1 control
    output logic             t0IrqClear,       // Timer 0 clear pulse
    output logic             t1IrqClear,       // Timer 1 clear pulse
    output logic [7:0]       remapSel,         // Memory remap control
    input  wire logic [7:0]  resetCauseIn,     // Reset cause, bit 0 power-on
    output logic [31:0]      calAddr,          // Calibration read address
    input  wire logic [31:0] calData,          // Calibration word
    output logic [2:0]       calIndex,         // Peripheral trim index
    output logic [31:0]      calValue,         // Trim value
    output logic             calWrite,         // Trim load pulse
    input  wire logic        dlRequestPin,     // Download request pin
    input  wire logic        userWdogEnable,   // User watchdog enable
    input  wire logic [23:0] userWdogLoad,     // User watchdog timeout
    input  wire logic        userWdogRefresh,  // User watchdog kick
    output logic             wdogReset,        // Watchdog expiry pulse
    output logic             booting,          // Boot sequence running
    output logic             downloadMode,     // Serial download active
    output logic             sramWriteAllow    // Boot may write SRAM
);
    mbs_pkg::mbs_boot_e state;
    logic [31:0] irqEnable, fiqEnable, serialLo, serialHi, checksum;
    logic [7:0]  resetStatus;
    logic        porBoot, dlMeta, dlReq, exitRefresh, dlRefresh, wdogRun;
    logic [23:0] bootCount, dlCount, wdogLoad, wdogCount;
    logic [11:0] off;
    logic        inSpace, wr, rd;
    logic [31:0] wv, readVal;

    // Narrow stores fill the low lanes and zero the rest
    function automatic logic [31:0] shapeWrite(input logic [31:0] d, input logic [1:0] sz);
        case (sz)
            mbs_pkg::SIZE_BYTE: shapeWrite = {24'h000000, d[7:0]};
            mbs_pkg::SIZE_HALF: shapeWrite = {16'h0000, d[15:0]}; // R16
            default:            shapeWrite = d; // R14
        endcase
    endfunction : shapeWrite

    function automatic logic [31:0] shapeRead(input logic [31:0] d, input logic [1:0] sz);
        case (sz)
            mbs_pkg::SIZE_BYTE: shapeRead = {24'h000000, d[7:0]};
            mbs_pkg::SIZE_HALF: shapeRead = {16'h0000, d[15:0]}; // R17
            default:            shapeRead = d; // R15
        endcase
    endfunction : shapeRead

    assign inSpace = busAddr[31:12] == mbs_pkg::SPACE_TAG; // R13 R19
    assign off     = busAddr[11:0];
    assign wr      = busSel && busWrite && inSpace;
    assign rd      = busSel && !busWrite && inSpace;
    assign wv      = shapeWrite(busWdata, busSize);
    assign irqActive = irqRaw & irqEnable;
    assign fiqActive = fiqRaw & fiqEnable;
    assign booting = state != mbs_pkg::B_USER;
    assign downloadMode = state == mbs_pkg::B_DOWNLOAD;
    assign sramWriteAllow = downloadMode; // R12

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            irqEnable <= mbs_pkg::RST_ZERO;
            fiqEnable <= mbs_pkg::RST_ZERO;
            softIrq   <= mbs_pkg::RST_ZERO;
        end else if (wr) begin
            case (off)
                mbs_pkg::OFF_IRQ_EN:  irqEnable <= irqEnable | wv;
                mbs_pkg::OFF_IRQ_DIS: irqEnable <= irqEnable & ~wv; // R20
                mbs_pkg::OFF_FIQ_EN:  fiqEnable <= fiqEnable | wv;
                mbs_pkg::OFF_FIQ_DIS: fiqEnable <= fiqEnable & ~wv; // R20
                mbs_pkg::OFF_SWI_CFG: softIrq <= wv;
                default: begin
                end
            endcase
        end
    end

    // Cause is caught on the first edge after release, never under reset
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            resetStatus <= 8'h00;
            porBoot     <= 1'b0;
        end else if (state == mbs_pkg::B_CAPTURE) begin
            resetStatus <= resetCauseIn;
            porBoot     <= resetCauseIn[mbs_pkg::POR_BIT];
        end else if (wr && off == mbs_pkg::OFF_RST_CLR) begin
            resetStatus <= resetStatus & ~wv[7:0]; // R21
        end else if (wr && off == mbs_pkg::OFF_RST_STAT) begin
            resetStatus <= resetStatus | wv[7:0];
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            remapSel <= 8'h00;
            serialLo <= mbs_pkg::RST_ZERO;
            serialHi <= mbs_pkg::RST_FW_REVISION; // R4
        end else if (wr) begin
            case (off)
                mbs_pkg::OFF_REMAP:  remapSel <= wv[7:0];
                mbs_pkg::OFF_SER_LO: serialLo <= wv;
                mbs_pkg::OFF_SER_HI: serialHi <= wv;
                default: begin
                end
            endcase
        end
    end

    // Boot owns the checksum while it copies; stores win afterwards
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            checksum <= mbs_pkg::RST_ZERO;
        end else if (state == mbs_pkg::B_CAPTURE) begin
            checksum <= mbs_pkg::RST_ZERO;
        end else if (state == mbs_pkg::B_COPY) begin
            checksum <= checksum + calData; // R3
        end else if (wr && off == mbs_pkg::OFF_CHKSUM) begin
            checksum <= wv;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            t0Reload  <= 16'h0000;
            t0Control <= mbs_pkg::RST_ZERO;
            t0Capture <= 16'h0000;
            t1Reload  <= mbs_pkg::RST_ZERO;
            t1Control <= mbs_pkg::RST_T1_CTRL;
        end else if (wr) begin
            case (off)
                mbs_pkg::OFF_T0_RELOAD: t0Reload  <= wv[15:0];
                mbs_pkg::OFF_T0_CTRL:   t0Control <= wv;
                mbs_pkg::OFF_T0_CAP:    t0Capture <= wv[15:0];
                mbs_pkg::OFF_T1_RELOAD: t1Reload  <= wv; // R16
                mbs_pkg::OFF_T1_CTRL:   t1Control <= wv;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            t0IrqClear <= 1'b0;
            t1IrqClear <= 1'b0;
        end else begin
            t0IrqClear <= wr && off == mbs_pkg::OFF_T0_ICLR;
            t1IrqClear <= wr && off == mbs_pkg::OFF_T1_ICLR;
        end
    end

    always_comb begin
        case (off)
            mbs_pkg::OFF_IRQ_ACTIVE: readVal = irqActive;
            mbs_pkg::OFF_IRQ_RAW:    readVal = irqRaw;
            mbs_pkg::OFF_IRQ_EN:     readVal = irqEnable;
            mbs_pkg::OFF_FIQ_ACTIVE: readVal = fiqActive;
            mbs_pkg::OFF_FIQ_RAW:    readVal = fiqRaw;
            mbs_pkg::OFF_FIQ_EN:     readVal = fiqEnable;
            mbs_pkg::OFF_REMAP:      readVal = {24'h000000, remapSel};
            mbs_pkg::OFF_RST_STAT:   readVal = {24'h000000, resetStatus};
            mbs_pkg::OFF_SER_LO:     readVal = serialLo;
            mbs_pkg::OFF_SER_HI:     readVal = serialHi; // R4
            mbs_pkg::OFF_CHKSUM:     readVal = checksum;
            mbs_pkg::OFF_T0_RELOAD:  readVal = {16'h0000, t0Reload};
            mbs_pkg::OFF_T0_CNT_LO:  readVal = {16'h0000, t0CountLo};
            mbs_pkg::OFF_T0_CNT_HI:  readVal = t0CountHi;
            mbs_pkg::OFF_T0_CTRL:    readVal = t0Control;
            mbs_pkg::OFF_T0_CAP:     readVal = {16'h0000, t0Capture};
            mbs_pkg::OFF_T1_RELOAD:  readVal = t1Reload;
            mbs_pkg::OFF_T1_CNT:     readVal = t1CountIn;
            mbs_pkg::OFF_T1_CTRL:    readVal = t1Control;
            mbs_pkg::OFF_T1_CAP:     readVal = t1CaptureIn;
            default:                 readVal = mbs_pkg::RST_ZERO; // R22
        endcase
    end

    // Loads outside the page answer zero so the core never hangs
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            busRdata <= mbs_pkg::RST_ZERO;
            busReady <= 1'b0;
        end else begin
            busReady <= busSel;
            if (busSel) begin
                busRdata <= rd ? shapeRead(readVal, busSize) : mbs_pkg::RST_ZERO; // R22
            end
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            dlMeta <= 1'b0;
            dlReq  <= 1'b0;
        end else begin
            dlMeta <= dlRequestPin;
            dlReq  <= dlMeta;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state     <= mbs_pkg::B_CAPTURE;
            calIndex  <= 3'h0;
            bootCount <= 24'h000000;
        end else begin
            if (state != mbs_pkg::B_DOWNLOAD && state != mbs_pkg::B_USER) begin
                bootCount <= bootCount + 24'h000001;
            end
            case (state)
                mbs_pkg::B_CAPTURE: state <= mbs_pkg::B_COPY; // R2
                mbs_pkg::B_COPY: begin
                    calIndex <= calIndex + 3'h1;
                    if (calIndex == 3'(mbs_pkg::CAL_WORDS - 1)) begin
                        state <= mbs_pkg::B_WAIT;
                    end
                end
                mbs_pkg::B_WAIT: begin
                    if (dlReq) begin
                        state <= mbs_pkg::B_DOWNLOAD;
                    end else if (bootCount >= 24'(BOOT_CYCLES - 1)) begin
                        state <= mbs_pkg::B_USER; // R10
                    end
                end
                mbs_pkg::B_DOWNLOAD: state <= mbs_pkg::B_DOWNLOAD; // R11
                mbs_pkg::B_USER:     state <= mbs_pkg::B_USER;
                default:             state <= mbs_pkg::B_CAPTURE;
            endcase
        end
    end

    assign calAddr = mbs_pkg::BOOT_REGION_BASE + {27'h0000000, calIndex, 2'h0}; // R1

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            calValue <= mbs_pkg::RST_ZERO;
            calWrite <= 1'b0;
        end else begin
            calWrite <= state == mbs_pkg::B_COPY; // R2
            if (state == mbs_pkg::B_COPY) begin
                calValue <= calData;
            end
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            exitRefresh <= 1'b0;
            dlRefresh   <= 1'b0;
            dlCount     <= 24'h000000;
        end else begin
            exitRefresh <= state == mbs_pkg::B_WAIT && !dlReq && !porBoot
                           && bootCount >= 24'(BOOT_CYCLES - 1); // R7
            dlRefresh   <= downloadMode && dlCount == 24'(DL_REFRESH_CYCLES - 1); // R9
            if (!downloadMode || dlCount == 24'(DL_REFRESH_CYCLES - 1)) begin
                dlCount <= 24'h000000;
            end else begin
                dlCount <= dlCount + 24'h000001;
            end
        end
    end

    // After power-on the user enable resets low, so exit leaves it off
    assign wdogRun  = (booting && porBoot) || userWdogEnable; // R5 R6 R7
    assign wdogLoad = (booting && porBoot) ? 24'(WDOG_BOOT_CYCLES) : userWdogLoad; // R5

    mbs_watchdog u_wdog (
        .clock   (clock),
        .sys_rst (sys_rst),
        .enable  (wdogRun),
        .load    (wdogLoad),
        .refresh (exitRefresh || dlRefresh || userWdogRefresh),
        .expired (wdogReset),
        .count   (wdogCount)
    );

    sequence s_normalExit;
        state == mbs_pkg::B_WAIT && !dlReq && bootCount >= 24'(BOOT_CYCLES - 1);
    endsequence

    a_irq_disable: assert property (@(posedge clock) disable iff (sys_rst)
        wr && off == mbs_pkg::OFF_IRQ_DIS |=> (irqEnable & $past(wv)) == 32'h00000000) // R20
        else $error("irq disable left bits set");
    a_rst_clear: assert property (@(posedge clock) disable iff (sys_rst)
        wr && off == mbs_pkg::OFF_RST_CLR && state != mbs_pkg::B_CAPTURE
        |=> (resetStatus & $past(wv[7:0])) == 8'h00) // R21
        else $error("reset flags not cleared");
    a_unmapped_zero: assert property (@(posedge clock) disable iff (sys_rst)
        busSel && !busWrite && (!inSpace || off == mbs_pkg::OFF_IRQ_DIS)
        |=> busReady && busRdata == 32'h00000000) // R22
        else $error("unmapped read not zero");
    a_half_write: assert property (@(posedge clock) disable iff (sys_rst)
        wr && off == mbs_pkg::OFF_T1_RELOAD && busSize == mbs_pkg::SIZE_HALF
        |=> t1Reload == {16'h0000, $past(busWdata[15:0])}) // R16
        else $error("half write upper not zero");
    a_half_read: assert property (@(posedge clock) disable iff (sys_rst)
        busSel && !busWrite && busSize == mbs_pkg::SIZE_HALF |=> busRdata[31:16] == 16'h0000) // R17
        else $error("half read wider than 16 bits");
    a_dl_sticky: assert property (@(posedge clock) disable iff (sys_rst)
        downloadMode |=> downloadMode && sramWriteAllow) // R11
        else $error("download mode left");
    a_sram_kept: assert property (@(posedge clock) disable iff (sys_rst)
        !downloadMode |-> !sramWriteAllow) // R12
        else $error("sram write outside download");
    a_boot_wdog: assert property (@(posedge clock) disable iff (sys_rst)
        booting && porBoot |-> wdogRun && wdogLoad == 24'(WDOG_BOOT_CYCLES)) // R5
        else $error("boot watchdog not at 30 ms");
    a_exit_refresh: assert property (@(posedge clock) disable iff (sys_rst)
        s_normalExit ##0 !porBoot |=> exitRefresh && !booting) // R7
        else $error("no refresh at boot exit");
    a_dl_refresh: assert property (@(posedge clock) disable iff (sys_rst)
        downloadMode |-> dlCount < 24'(DL_REFRESH_CYCLES)) // R9
        else $error("download refresh overdue");
    a_cal_copy: assert property (@(posedge clock) disable iff (sys_rst)
        $fell(state == mbs_pkg::B_CAPTURE) |=> calWrite[*8] ##1 !calWrite) // R2
        else $error("calibration copy not eight words");
    a_bus_answer: assert property (@(posedge clock) disable iff (sys_rst)
        busSel |=> busReady) // R14
        else $error("access not answered");
endmodule : mbs_mmr_boot

/* mbs_core_model.sv */
// Purpose: Core model issuing loads and stores
// Assumes: Answer one cycle after the request
// Notes:   Released lines show inverted values, except busSize, which keeps its value
`timescale 1ns/1ps
module mbs_core_model (
    input  wire logic        clock,     // Clock
    input  wire logic [31:0] busRdata,  // Load data
    input  wire logic        busReady,  // Answer
    output logic             busSel,    // Request
    output logic             busWrite,  // Store
    output logic [1:0]       busSize,   // Size
    output logic [31:0]      busAddr,   // Address
    output logic [31:0]      busWdata); // Store data
    initial {busSel, busWrite, busSize, busAddr, busWdata} = '0;
    task automatic access(input logic w, logic [1:0] sz, logic [31:0] a, d,
                          output logic [31:0] rd, output logic ok);
        @(negedge clock);
        {busSel, busWrite, busSize, busAddr, busWdata} = {1'b1, w, sz, a, d};
        @(negedge clock);
        {ok, rd} = {busReady, busRdata};
        {busSel, busWrite, busAddr, busWdata} = {1'b0, ~w, ~a, ~d};
    endtask : access
endmodule : mbs_core_model

/* mbs_mmr_boot_tb.sv */
// Purpose: Self-checking bench for register page and boot
// Assumes: Boot 40, boot watchdog 200, refresh 10 cycles
// Notes:   Accesses go through the core model
`timescale 1ns/1ps
module mbs_mmr_boot_tb;
    localparam int BOOT = 40, WDOG = 200;
    logic        clock = 1'b0, sys_rst = 1'b1, dlRequestPin = 1'b0, ok, wdogReset;
    logic        uwEn = 1'b0;
    logic [7:0]  cause = 8'h01;
    logic [23:0] uwLoad = 24'h000000;
    logic        busSel, busWrite, busReady, calWrite, booting, downloadMode, sramWriteAllow;
    logic [1:0]  busSize;
    logic [31:0] busAddr, busWdata, busRdata, calAddr, rdv;
    int          n_errors = 0, cmp_count = 0, t, hits = 0, bad = 0;
    always #2 clock = ~clock;
    mbs_core_model core (.*);
    mbs_mmr_boot #(.BOOT_CYCLES(BOOT), .WDOG_BOOT_CYCLES(WDOG), .DL_REFRESH_CYCLES(10)) dut (.*,
        .irqRaw(calAddr), .fiqRaw(~calAddr), .t0CountLo(calAddr[15:0]), .t0CountHi(calAddr),
        .t1CountIn(calAddr), .t1CaptureIn(~calAddr), .calData(calAddr ^ 32'h5a5a0000),
        .resetCauseIn(cause), .userWdogEnable(uwEn), .userWdogLoad(uwLoad),
        .userWdogRefresh(1'b0), .irqActive(), .fiqActive(), .softIrq(), .t0Reload(),
        .t0Control(), .t0Capture(), .t1Reload(), .t1Control(), .t0IrqClear(), .t1IrqClear(),
        .remapSel(), .calIndex(), .calValue());
    task automatic chk(input string nm, input logic [31:0] exp, got);
        cmp_count++;
        n_errors += int'(got !== exp);
        if (got !== exp) $display("unexpected %s expected %h seen %h", nm, exp, got);
    endtask : chk
    task automatic bus(input logic w, logic [1:0] sz, logic [11:0] o, logic [31:0] d);
        core.access(w, sz, {20'hffff0, o}, d, rdv, ok);
        chk("busReady", 32'h1, {31'h0, ok});
        if (!w) chk("load data", d, rdv);
    endtask : bus
    task automatic power_on;
        repeat (16) @(negedge clock);
        sys_rst = 1'b0;
        for (t = 0; t < 100 && booting === 1'b1; t++) begin
            @(negedge clock);
            hits += int'(calWrite === 1'b1);
        end
        chk("calWrite pulses", 32'd8, 32'(hits));
        chk("boot length", 32'h1, {31'h0, t >= BOOT - 3 && t <= BOOT + 3});
        bus(1'b0, 2'h2, 12'h328, 32'h01000000);
        bus(1'b1, 2'h0, 12'h234, 32'h1);
        bus(1'b0, 2'h2, 12'h230, 32'h0);
        bus(1'b1, 2'h2, 12'h008, 32'h5);
        bus(1'b1, 2'h2, 12'h00c, 32'h1);
        bus(1'b0, 2'h2, 12'h008, 32'h4);
        bus(1'b1, 2'h2, 12'h320, 32'ha5a5c3c3);
        bus(1'b0, 2'h1, 12'h320, 32'h0000c3c3);
        bus(1'b1, 2'h1, 12'h320, 32'h12345678);
        bus(1'b0, 2'h2, 12'h320, 32'h00005678);
        bus(1'b0, 2'h2, 12'h23c, mbs_pkg::RST_FW_REVISION);
        bus(1'b0, 2'h2, 12'h00c, 32'h0);
        for (t = 0; t < WDOG + 20 && wdogReset !== 1'b1; t++) @(negedge clock);
        chk("watchdog quiet", 32'(WDOG + 20), 32'(t));
    endtask : power_on
    // Warm reset: user watchdog kept, so expiry moves out by the exit refresh
    task automatic warm_boot;
        sys_rst = 1'b1;
        cause   = 8'h02;
        uwEn    = 1'b1;
        uwLoad  = 24'(WDOG);
        repeat (16) @(negedge clock);
        sys_rst = 1'b0;
        for (t = 0; t < 2 * WDOG && wdogReset !== 1'b1; t++) @(negedge clock);
        chk("refreshed expiry", 32'h1,
            {31'h0, t >= WDOG + BOOT - 2 && t <= WDOG + BOOT + 4});
        chk("booting", 32'h0, {31'h0, booting});
    endtask : warm_boot
    task automatic download;
        sys_rst = 1'b1;
        cause   = 8'h01;
        uwEn    = 1'b0;
        dlRequestPin = 1'b1;
        repeat (16) @(negedge clock);
        sys_rst = 1'b0;
        for (t = 0; t < 60 && downloadMode !== 1'b1; t++) @(negedge clock);
        repeat (2 * WDOG) begin
            @(negedge clock);
            bad += int'(downloadMode !== 1'b1 || sramWriteAllow !== 1'b1 || wdogReset === 1'b1);
        end
        chk("download held", 32'h0, 32'(bad));
    endtask : download
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : print_verdict
    initial begin
        power_on();
        warm_boot();
        download();
        print_verdict();
    end
endmodule : mbs_mmr_boot_tb
